// [verilog/handler_digital_output_port.v]
/*
 * Handler digital output port: drives four lines toward a component
 * handler, restores a default pattern after a limit test, times the line 4
 * strobe and the skew of lines 1 to 3 around it. APB slave for registers.
 * Assumes test_done_in, test_pattern_in and busy_in come from logic on
 * clk_in, so they are used without synchronisers.
 */
`timescale 1ns/100ps
`include "handler_port_consts.vh"
`include "handler_port_consts_extra.vh"
module handler_digital_output_port #(
    parameter CYCLES_PER_US = `CYCLES_PER_US
) (
    // clock and reset
    input  wire        clk_in,
    input  wire        rst_n_in,
    // apb slave
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [7:0]  paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    // limit test result
    input  wire        test_done_in,
    input  wire [3:0]  test_pattern_in,
    input  wire        busy_in,
    // handler lines, bit 0 is line 1
    output reg  [3:0]  lines_out
);

    localparam ST_IDLE   = 3'h0;
    localparam ST_LEAD   = 3'h1;
    localparam ST_STROBE = 3'h2;
    localparam ST_TRAIL  = 3'h3;
    localparam ST_HOLD   = 3'h4;

    // settings
    reg         line4_function_select;
    reg         strobe_polarity;
    reg         auto_restore;
    reg  [2:0]  port_width_select;
    reg  [3:0]  default_pattern;
    reg  [25:0] restore_delay_us;

    // sequence state
    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [3:0]  test_pattern;
    reg  [25:0] strobe_us;
    reg  [25:0] elapsed_us;
    reg  [25:0] target_us;
    reg         restart_tick;
    reg  [3:0]  next_lines;
    reg  [31:0] next_prdata;
    reg         next_pslverr;
    reg         strobe_active;
    reg  [3:0]  shown;

    wire        us_tick;
    wire        setup_phase = psel_in && !penable_in;
    wire        wr_commit   = psel_in && penable_in && pready_out && pwrite_in;
    wire        restore_cmd = wr_commit && (paddr_in == `OFS_COMMAND) && pwdata_in[`CMD_RESTORE_BIT];
    wire        step_done   = (elapsed_us == target_us);

    // line 4 is a strobe unless four-line width with end-of-test selected
    function strobe_mode;
        input [2:0] width;
        input       func;
        begin
            strobe_mode = (width == `WIDTH_THREE) || (func == `FUNC_BUSY);
        end
    endfunction

    // a pattern is legal only within the range of the current width
    function pattern_ok;
        input [31:0] value;
        input [2:0]  width;
        begin
            if (value[31:4] != 28'h0000000)
                pattern_ok = 1'b0;
            else if (width == `WIDTH_THREE)
                pattern_ok = (value[3:0] <= `PATTERN_MAX_THREE);
            else
                pattern_ok = 1'b1;
        end
    endfunction

    us_tick_gen #(
        .DIVIDE     (CYCLES_PER_US)
    ) u_tick (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n_in),
        .restart_in (restart_tick),
        .tick_out   (us_tick)
    );

    // settings registers; a rejected write leaves the old value
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            line4_function_select <= `RST_FUNC;
            strobe_polarity       <= `RST_POLARITY;
            auto_restore          <= `RST_AUTO;
            port_width_select     <= `RST_WIDTH;
            default_pattern       <= `RST_DEFAULT;
            restore_delay_us      <= `DELAY_DEFAULT_US;
        end else if (wr_commit && !pslverr_out) begin
            if (paddr_in == `OFS_CONTROL) begin
                line4_function_select <= pwdata_in[`CTL_FUNC_BIT];
                strobe_polarity       <= pwdata_in[`CTL_POL_BIT];
                auto_restore          <= pwdata_in[`CTL_AUTO_BIT];
            end else if (paddr_in == `OFS_WIDTH) begin
                port_width_select <= pwdata_in[2:0];
                // a wide default that no longer fits three lines is narrowed
                if (pwdata_in[2:0] == `WIDTH_THREE)
                    default_pattern[3] <= 1'b0;
            end else if (paddr_in == `OFS_DEFAULT) begin
                default_pattern <= pwdata_in[3:0];
            end else if (paddr_in == `OFS_DELAY) begin
                restore_delay_us <= pwdata_in[25:0];
            end
        end
    end

    // read data and write checks, computed in the setup phase
    always @* begin
        next_prdata  = 32'h00000000;
        next_pslverr = 1'b0;
        if (paddr_in == `OFS_CONTROL) begin
            next_prdata[`CTL_FUNC_BIT] = line4_function_select;
            next_prdata[`CTL_POL_BIT]  = strobe_polarity;
            next_prdata[`CTL_AUTO_BIT] = auto_restore;
        end else if (paddr_in == `OFS_WIDTH) begin
            next_prdata[2:0] = port_width_select;
            if (pwrite_in && (pwdata_in != {29'h00000000, `WIDTH_THREE})
                          && (pwdata_in != {29'h00000000, `WIDTH_FOUR}))
                next_pslverr = 1'b1;
        end else if (paddr_in == `OFS_DEFAULT) begin
            next_prdata[3:0] = default_pattern;
            if (pwrite_in && !pattern_ok(pwdata_in, port_width_select))
                next_pslverr = 1'b1;
        end else if (paddr_in == `OFS_DELAY) begin
            next_prdata[25:0] = restore_delay_us;
            if (pwrite_in && ((pwdata_in[31:26] != 6'h00) || (pwdata_in[25:0] > `DELAY_MAX_US)))
                next_pslverr = 1'b1;
        end else if (paddr_in == `OFS_COMMAND) begin
            next_prdata = 32'h00000000;
        end else if (paddr_in == `OFS_ACTUAL) begin
            next_prdata[3:0] = lines_out;
            if (pwrite_in)
                next_pslverr = 1'b1;
        end else if (paddr_in == `OFS_STATUS) begin
            next_prdata[`STS_PENDING_BIT] = (state != ST_IDLE);
            next_prdata[`STS_STROBE_BIT]  = strobe_active;
            if (pwrite_in)
                next_pslverr = 1'b1;
        end else begin
            next_pslverr = 1'b1;
        end
    end

    // one access cycle per transfer: pready rises after every setup phase
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            prdata_out  <= 32'h00000000;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else if (setup_phase) begin
            prdata_out  <= pwrite_in ? 32'h00000000 : next_prdata;
            pready_out  <= 1'b1;
            pslverr_out <= next_pslverr;
        end else begin
            prdata_out  <= 32'h00000000;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end
    end

    // which interval the microsecond count is compared against
    always @* begin
        if (state == ST_STROBE)
            target_us = strobe_us;
        else
            target_us = `SKEW_US;
    end

    // sequence: lead skew, strobe, trail skew, then restore or hold
    always @* begin
        next_state   = state;
        restart_tick = 1'b0;
        if (test_done_in) begin
            next_state   = ST_LEAD;
            restart_tick = 1'b1;
        end else if (restore_cmd) begin
            next_state = ST_IDLE;
        end else begin
            case (state)
            ST_LEAD: begin
                if (step_done) begin
                    next_state   = ST_STROBE;
                    restart_tick = 1'b1;
                end
            end
            ST_STROBE: begin
                if (step_done) begin
                    next_state   = ST_TRAIL;
                    restart_tick = 1'b1;
                end
            end
            ST_TRAIL: begin
                if (step_done) begin
                    if (auto_restore)
                        next_state = ST_IDLE;
                    else
                        next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                next_state = ST_HOLD;
            end
            default: begin
                next_state = ST_IDLE;
            end
            endcase
        end
    end

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            state        <= ST_IDLE;
            test_pattern <= 4'h0;
            strobe_us    <= `DELAY_DEFAULT_US;
            elapsed_us   <= 26'h0000000;
        end else begin
            state <= next_state;
            if (test_done_in) begin
                test_pattern <= test_pattern_in;
                // the delay is frozen per test so a rewrite cannot cut a strobe short
                strobe_us    <= restore_delay_us;
            end
            if (restart_tick)
                elapsed_us <= 26'h0000000;
            else if (us_tick && !step_done)
                elapsed_us <= elapsed_us + 26'h0000001;
        end
    end

    // strobe meaning depends on the selected function
    always @* begin
        if (line4_function_select == `FUNC_BUSY)
            strobe_active = busy_in;
        else
            strobe_active = (state == ST_STROBE);
    end

    // line drive: default pattern at rest, test pattern during a sequence
    always @* begin
        if (state == ST_IDLE)
            shown = default_pattern;
        else
            shown = test_pattern;
        next_lines[2:0] = shown[2:0];
        if (strobe_mode(port_width_select, line4_function_select))
            next_lines[3] = strobe_polarity ? strobe_active : !strobe_active;
        else
            next_lines[3] = shown[3];
    end

    always @(posedge clk_in) begin
        if (!rst_n_in)
            lines_out <= {!`RST_POLARITY, `RST_DEFAULT_LOW};
        else
            lines_out <= next_lines;
    end

endmodule

// [verilog/handler_port_consts.vh]
/*
 * Constants for the handler digital output port: register offsets, field
 * positions, reset values and timing figures.
 * Assumes a 50 MHz system clock and a 32-bit APB register bus.
 */
`ifndef HANDLER_PORT_CONSTS_VH
`define HANDLER_PORT_CONSTS_VH

// register byte offsets
`define OFS_CONTROL         8'h00
`define OFS_WIDTH           8'h04
`define OFS_DEFAULT         8'h08
`define OFS_DELAY           8'h0C
`define OFS_COMMAND         8'h10
`define OFS_ACTUAL          8'h14
`define OFS_STATUS          8'h18

// control register fields
`define CTL_FUNC_BIT        0
`define CTL_POL_BIT         1
`define CTL_AUTO_BIT        2

// command register fields
`define CMD_RESTORE_BIT     0

// status register fields
`define STS_PENDING_BIT     0
`define STS_STROBE_BIT      1

// field values
`define FUNC_END_OF_TEST    1'b0
`define FUNC_BUSY           1'b1
`define WIDTH_THREE         3'h3
`define WIDTH_FOUR          3'h4
`define PATTERN_MAX_THREE   4'h7

// reset values
`define RST_FUNC            1'b0
`define RST_POLARITY        1'b1
`define RST_AUTO            1'b1
`define RST_WIDTH           3'h3
`define RST_DEFAULT         4'h0

// timing
`define CLK_FREQ_HZ         50000000
`define US_PER_S            1000000
`define CYCLES_PER_US       (`CLK_FREQ_HZ / `US_PER_S)
`define SKEW_US             26'h000000A
`define DELAY_DEFAULT_US    26'h0000064
`define DELAY_MAX_US        26'h3938700

`endif

// [verilog/us_tick_gen.v]
/*
 * Microsecond tick generator: a one-cycle pulse every DIVIDE clocks.
 * Assumes restart_in comes from logic on the same clock; a restart makes
 * the next tick a full microsecond away.
 */
`timescale 1ns/100ps
module us_tick_gen #(
    parameter DIVIDE = 50
) (
    // clock and reset
    input  wire       clk_in,
    input  wire       rst_n_in,
    // control
    input  wire       restart_in,
    // tick
    output reg        tick_out
);

    reg  [7:0] count;

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            count    <= 8'h00;
            tick_out <= 1'b0;
        end else if (restart_in) begin
            count    <= 8'h00;
            tick_out <= 1'b0;
        end else if (count == DIVIDE[7:0] - 8'h01) begin
            count    <= 8'h00;
            tick_out <= 1'b1;
        end else begin
            count    <= count + 8'h01;
            tick_out <= 1'b0;
        end
    end

endmodule

// [verilog/handler_port_consts_extra.vh]
/*
 * Additional reset constant for the line drive.
 * Assumes handler_port_consts.vh is included first.
 */
`ifndef HANDLER_PORT_CONSTS_EXTRA_VH
`define HANDLER_PORT_CONSTS_EXTRA_VH
`define RST_DEFAULT_LOW     3'h0
`endif

// [verification/port_checks_asserts.sv]
/* checker: bus answer timing, refusals, restore and test lead.
   assumes it is bound to the port top with the port header on the path. */
`timescale 1ns/100ps
`include "handler_port_consts.vh"
module port_checks (
    input wire        clk_in,
    input wire        rst_n_in,
    input wire        psel_in,
    input wire        penable_in,
    input wire        pwrite_in,
    input wire [7:0]  paddr_in,
    input wire [31:0] pwdata_in,
    input wire [31:0] prdata_out,
    input wire        pready_out,
    input wire        pslverr_out,
    input wire        test_done_in,
    input wire [3:0]  test_pattern_in,
    input wire        busy_in,
    input wire [3:0]  lines_out
);
    reg  [3:0] dflt;
    wire       acc = psel_in && penable_in && pready_out;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // shadow of the accepted default, so restores can be judged
    always @(posedge clk_in) begin
        if (!rst_n_in)
            dflt <= 4'h0;
        else if (acc && pwrite_in && !pslverr_out && paddr_in == `OFS_DEFAULT)
            dflt <= pwdata_in[3:0];
    end
    a_ready_once: assert property (pready_out |=> !pready_out) else $error("ready held");
    a_setup_answer: assert property (psel_in && !penable_in |=> pready_out) else $error("no answer");
    a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0) else $error("stray data");
    a_width_refuse: assert property (acc && pwrite_in && paddr_in == `OFS_WIDTH
        && pwdata_in != 3 && pwdata_in != 4 |-> pslverr_out) else $error("bad width taken");
    a_map_refuse: assert property (acc && paddr_in > `OFS_STATUS |-> pslverr_out) else $error("hole taken");
    a_restore_now: assert property (acc && pwrite_in && paddr_in == `OFS_COMMAND && pwdata_in[0]
        && !test_done_in |-> ##[1:2] lines_out[2:0] == dflt[2:0]) else $error("no restore");
    a_test_lead: assert property (test_done_in
        |-> ##2 lines_out[2:0] == $past(test_pattern_in, 2)) else $error("pattern late");
    a_lead_skew: assert property (test_done_in |-> ##3 $stable(lines_out[3]) [*8]) else $error("strobe early");
endmodule
bind handler_digital_output_port port_checks checks_u (.clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .test_done_in, .test_pattern_in, .busy_in,
    .lines_out);

// [verification/handler_model.sv]
/* handler model: reads the category lines only while the strobe is active.
   assumes the bench supplies the strobe polarity and a clear pulse. */
`timescale 1ns/100ps
module handler_model (
    // clock and control
    input  wire       clk_in,
    input  wire       pol_in,
    input  wire       clear_in,
    // lines from the port
    input  wire [3:0] lines_in,
    // what the handler saw
    output reg  [2:0] category_out,
    output reg  [7:0] strobe_len_out
);
    initial begin
        category_out = 3'h0;
        strobe_len_out = 8'h00;
    end
    // lines 1 to 3 are trusted only inside the strobe, where skew gives margin
    always @(posedge clk_in) begin
        if (clear_in)
            strobe_len_out <= 8'h00;
        else if (lines_in[3] == pol_in) begin
            category_out <= lines_in[2:0];
            strobe_len_out <= strobe_len_out + 8'h01;
        end
    end
endmodule

// [verification/test_handler_digital_output_port.sv]
/* bench for the handler output port: apb tasks, one task per scenario.
   assumes the port, its checker and the handler model are compiled. */
`timescale 1ns/100ps
`include "handler_port_consts.vh"
module test_handler_digital_output_port;
    reg         clk_in = 1'b0;
    reg         rst_n_in = 1'b0;
    reg         psel_in = 1'b0;
    reg         penable_in = 1'b0;
    reg         pwrite_in = 1'b0;
    reg  [7:0]  paddr_in = 8'h00;
    reg  [31:0] pwdata_in = 32'h0;
    reg         test_done_in = 1'b0;
    reg  [3:0]  test_pattern_in = 4'h0;
    reg         busy_in = 1'b0;
    reg         pol = 1'b1;
    reg         hclr = 1'b0;
    wire [31:0] prdata_out;
    wire        pready_out;
    wire        pslverr_out;
    wire [3:0]  lines_out;
    wire [2:0]  cat;
    wire [7:0]  slen;
    integer     miscompares = 0;
    integer     checks = 0;
    integer     cycles = 0;
    integer     n;
    reg  [31:0] rd;
    reg         er;
    // two cycles a microsecond keeps the 10 us skews short
    handler_digital_output_port #(.CYCLES_PER_US(2)) dut (.clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in,
        .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .test_done_in, .test_pattern_in, .busy_in,
        .lines_out);
    handler_model hm (.clk_in, .pol_in(pol), .clear_in(hclr), .lines_in(lines_out), .category_out(cat),
        .strobe_len_out(slen));
    always #10 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            miscompares = miscompares + 1;
            test_done;
        end
    end
    task test_done;
        begin
            $display("checks %0d miscompares %0d", checks, miscompares);
            if (miscompares == 0 && checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("MISMATCH %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk_in);
            psel_in <= 1'b1;
            pwrite_in <= w;
            paddr_in <= a;
            pwdata_in <= d;
            @(posedge clk_in);
            penable_in <= 1'b1;
            @(posedge clk_in);
            while (pready_out !== 1'b1)
                @(posedge clk_in);
            rd = prdata_out;
            er = pslverr_out;
            psel_in <= 1'b0;
            penable_in <= 1'b0;
        end
    endtask
    task rdc(input [7:0] a, input [31:0] e);
        begin
            apb(1'b0, a, 32'h0);
            chk(rd, e);
        end
    endtask
    task wl(input [3:0] m, input [3:0] e);
        begin
            n = 0;
            while ((lines_out & m) !== e && n < 200) begin
                @(posedge clk_in);
                n = n + 1;
            end
            chk(lines_out & m, e);
        end
    endtask
    task pulse(input [3:0] p);
        begin
            @(posedge clk_in);
            test_done_in <= 1'b1;
            test_pattern_in <= p;
            hclr <= 1'b1;
            @(posedge clk_in);
            test_done_in <= 1'b0;
            hclr <= 1'b0;
        end
    endtask
    task run(input [3:0] p);
        begin
            pulse(p);
            n = 0;
            while (lines_out[3] !== pol && n < 100) begin
                @(posedge clk_in);
                n = n + 1;
            end
            chk(n >= 20 && n <= 26, 1);
            while (lines_out[3] === pol)
                @(posedge clk_in);
            chk(cat, p[2:0]);
            chk(slen >= 6 && slen <= 8, 1);
        end
    endtask
    task t_reset;
        begin
            rdc(`OFS_CONTROL, 6);
            rdc(`OFS_WIDTH, 3);
            rdc(`OFS_DELAY, 100);
            chk(lines_out, 0);
            $display("reset test done");
        end
    endtask
    task t_regs;
        begin
            apb(1'b1, `OFS_WIDTH, 5);
            chk(er, 1);
            apb(1'b1, `OFS_DEFAULT, 8);
            chk(er, 1);
            apb(1'b1, `OFS_DELAY, 60000001);
            chk(er, 1);
            apb(1'b1, `OFS_DELAY, 60000000);
            chk(er, 0);
            apb(1'b1, `OFS_ACTUAL, 3);
            chk(er, 1);
            apb(1'b0, 8'h1C, 0);
            chk(er, 1);
            apb(1'b1, `OFS_DEFAULT, 5);
            wl(4'hF, 4'h5);
            rdc(`OFS_ACTUAL, 5);
            $display("register test done");
        end
    endtask
    task t_auto;
        begin
            apb(1'b1, `OFS_DELAY, 3);
            run(2);
            wl(4'hF, 4'h5);
            pulse(1);
            repeat (8) @(posedge clk_in);
            run(3);
            wl(4'hF, 4'h5);
            $display("auto restore test done");
        end
    endtask
    task t_hold;
        begin
            apb(1'b1, `OFS_CONTROL, 2);
            pulse(6);
            repeat (100) @(posedge clk_in);
            chk(lines_out, 6);
            rdc(`OFS_STATUS, 1);
            rdc(`OFS_DEFAULT, 5);
            rdc(`OFS_ACTUAL, 6);
            apb(1'b1, `OFS_COMMAND, 1);
            wl(4'hF, 4'h5);
            rdc(`OFS_STATUS, 0);
            $display("hold test done");
        end
    endtask
    task t_modes;
        begin
            apb(1'b1, `OFS_CONTROL, 4);
            pol <= 1'b0;
            wl(4'h8, 4'h8);
            run(4);
            wl(4'hF, 4'hD);
            apb(1'b1, `OFS_CONTROL, 6);
            pol <= 1'b1;
            apb(1'b1, `OFS_WIDTH, 4);
            chk(er, 0);
            apb(1'b1, `OFS_DEFAULT, 13);
            wl(4'hF, 4'hD);
            apb(1'b1, `OFS_CONTROL, 7);
            wl(4'hF, 4'h5);
            busy_in <= 1'b1;
            wl(4'h8, 4'h8);
            rdc(`OFS_STATUS, 2);
            busy_in <= 1'b0;
            wl(4'hF, 4'h5);
            $display("mode test done");
        end
    endtask
    initial begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_reset;
        t_regs;
        t_auto;
        t_hold;
        t_modes;
        test_done;
    end
endmodule
